// ==== src/nims_pkg.sv ====
// Function
// - mask bit 7 gates the timer rollover flag onto the interrupt
// - mask bit 6 gates the receive descriptors exhausted flag
// - mask bit 5 gates the receive resources exhausted flag
// - mask bit 4 gates the receive buffer area overflow flag
// - mask bit 3 gates the checksum tally counter wrap flag
// - mask bit 2 gates the alignment tally counter wrap flag
// - mask bit 1 gates the missed packet tally counter wrap flag
// - mask bit 0 gates the receive fifo overrun flag
// - interrupt only for enabled flags; active interrupt implies some flag set
// - writing one clears a flag, writing zero leaves it
// - hardware reset clears flags, software reset leaves them
// - bit 14 on bus retry; latched mode: master only, dma held till cleared
// - unlatched retry mode: dma resumes without waiting for the flag
// - bit 13 when no heartbeat within 6.4 us after transmission
// - bit 12 when address filter load has written every entry
// - bit 11 when descriptor config word has interrupt request bit set
// - bit 10 after received packet sequence word written
// - bit 9 on end of list marker or halt transmit command
// - bit 9 also on transmit abort from any of four errors
// - bit 9 set only after transmit status word written
// - hardware reset clears mask; writing one enables that flag's interrupt
// - bit 8 when packet sent with any of the four transmit errors
package nims_pkg;
  localparam int unsigned DATA_W  = 16;
  // printed offsets 4 and 5 are register indices; byte address is 4x
  localparam logic [7:0]  IDX_MASK = 8'h04;
  localparam logic [7:0]  IDX_FLAGS = 8'h05;
  localparam logic [11:0] ADDR_MASK = {2'h0, IDX_MASK, 2'h0};
  localparam logic [11:0] ADDR_FLAGS = {2'h0, IDX_FLAGS, 2'h0};
  localparam logic [11:0] ADDR_CTRL = 12'h018;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] WR_MASK = 16'h7fff;
  localparam int unsigned CTRL_LATCHED_BIT = 0;
  localparam int unsigned CTRL_SWRST_BIT = 1;
  localparam int unsigned B_RFO = 0;
  localparam int unsigned B_MP = 1;
  localparam int unsigned B_FAE = 2;
  localparam int unsigned B_CRC = 3;
  localparam int unsigned B_AREA = 4;
  localparam int unsigned B_RES = 5;
  localparam int unsigned B_DESC = 6;
  localparam int unsigned B_TMR = 7;
  localparam int unsigned B_TRANSMIT_ERROR_FLAG = 8;
  localparam int unsigned B_TRANSMISSION_DONE_FLAG = 9;
  localparam int unsigned B_PACKET_RECEIVED_FLAG = 10;
  localparam int unsigned B_PROGRAMMED_IRQ_FLAG = 11;
  localparam int unsigned B_CAM = 12;
  localparam int unsigned B_HBL = 13;
  localparam int unsigned B_BR = 14;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned HB_WINDOW_NS = 6400;
  // longest time: rounded down
  localparam int unsigned HB_WINDOW_CYC = (HB_WINDOW_NS * CLK_MHZ) / 1000;
  localparam logic [31:0] TMR_WRAP_FROM = 32'h00000000;
  localparam logic [31:0] TMR_WRAP_TO = 32'hffffffff;
  localparam logic [15:0] TALLY_WRAP_FROM = 16'hffff;
  localparam logic [15:0] TALLY_WRAP_TO = 16'h0000;
endpackage

// ==== src/nims_top.sv ====
// Register access over APB was decided locally.
`timescale 1ns/1ps
module nims_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bus_retry_input,
  input  wire logic        bus_master,
  input  wire logic        tx_frame_end,
  input  wire logic        heartbeat_pulse,
  input  wire logic        cam_load_done,
  input  wire logic        tx_config_read,
  input  wire logic        descriptor_irq_request_bit,
  input  wire logic        rx_seq_word_written,
  input  wire logic        tx_status_written,
  input  wire logic        end_of_list_marker,
  input  wire logic        halt_transmit_command,
  input  wire logic        byte_count_mismatch,
  input  wire logic        too_many_collisions,
  input  wire logic        fifo_underrun_error,
  input  wire logic        too_long_deferral,
  input  wire logic [31:0] timer_value,
  input  wire logic        rx_descriptors_out,
  input  wire logic        rx_resources_out,
  input  wire logic        rx_area_overflow,
  input  wire logic [15:0] checksum_tally,
  input  wire logic [15:0] alignment_tally,
  input  wire logic [15:0] missed_tally,
  input  wire logic        rx_fifo_overflow,
  output logic             irq,
  output logic             dma_hold,
  output logic             soft_reset
);
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [15:0] interrupt_enable_mask_ff;
  logic [15:0] interrupt_cause_flags_ff;
  logic        latched_retry_mode_ff;
  logic [15:0] ev;
  logic [15:0] w1c;
  logic        wr_acc;
  logic        rd_acc;
  logic [31:0] nxt_prdata;
  logic        addr_ok;

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;
  assign addr_ok = (paddr == nims_pkg::ADDR_MASK) | (paddr == nims_pkg::ADDR_FLAGS) |
                   (paddr == nims_pkg::ADDR_CTRL);

  // ------------------------------------------------------------
  // event capture
  // ------------------------------------------------------------
  logic [31:0] tmr_prev_ff;
  logic [15:0] crc_prev_ff;
  logic [15:0] fae_prev_ff;
  logic [15:0] mp_prev_ff;
  logic        hb_armed_ff;
  logic [7:0]  hb_cnt_ff;
  logic        hb_miss;
  logic        tx_err;
  logic        programmed_irq_flag_pend_ff;
  logic        done_pend_ff;
  logic        err_pend_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // idle timer sits at all ones; a zero here would fake a wrap after reset
      tmr_prev_ff <= nims_pkg::TMR_WRAP_TO;
      crc_prev_ff <= 16'h0000;
      fae_prev_ff <= 16'h0000;
      mp_prev_ff  <= 16'h0000;
    end else begin
      tmr_prev_ff <= timer_value;
      crc_prev_ff <= checksum_tally;
      fae_prev_ff <= alignment_tally;
      mp_prev_ff  <= missed_tally;
    end
  end

  // heartbeat window opens at end of transmission
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hb_armed_ff <= 1'b0;
      hb_cnt_ff   <= 8'h00;
    end else if (tx_frame_end) begin
      hb_armed_ff <= 1'b1;
      hb_cnt_ff   <= 8'h00;
    end else if (hb_armed_ff) begin
      if (heartbeat_pulse || hb_miss) begin
        hb_armed_ff <= 1'b0;
      end
      hb_cnt_ff <= hb_cnt_ff + 8'h01;
    end
  end
  assign hb_miss = hb_armed_ff & ~heartbeat_pulse &
                   (hb_cnt_ff == 8'(nims_pkg::HB_WINDOW_CYC - 1));

  assign tx_err = byte_count_mismatch | too_many_collisions |
                  fifo_underrun_error | too_long_deferral;

  // tx outcomes wait until the status word is written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_pend_ff <= 1'b0;
      err_pend_ff  <= 1'b0;
    end else if (tx_status_written) begin
      done_pend_ff <= 1'b0;
      err_pend_ff  <= 1'b0;
    end else begin
      if (end_of_list_marker || halt_transmit_command || tx_err) begin
        done_pend_ff <= 1'b1;
      end
      if (tx_err) begin
        err_pend_ff <= 1'b1;
      end
    end
  end

  logic done_now;
  logic err_now;
  assign done_now = tx_status_written &
                    (done_pend_ff | end_of_list_marker | halt_transmit_command | tx_err);
  assign err_now = tx_status_written & (err_pend_ff | tx_err);

  always_comb begin
    ev = 16'h0000;
    ev[nims_pkg::B_BR]    = bus_retry_input & (bus_master | ~latched_retry_mode_ff);
    ev[nims_pkg::B_HBL]   = hb_miss;
    ev[nims_pkg::B_CAM]   = cam_load_done;
    ev[nims_pkg::B_PROGRAMMED_IRQ_FLAG]  = tx_config_read & descriptor_irq_request_bit;
    ev[nims_pkg::B_PACKET_RECEIVED_FLAG] = rx_seq_word_written;
    ev[nims_pkg::B_TRANSMISSION_DONE_FLAG]  = done_now;
    ev[nims_pkg::B_TRANSMIT_ERROR_FLAG]  = err_now;
    ev[nims_pkg::B_TMR]   = (tmr_prev_ff == nims_pkg::TMR_WRAP_FROM) &
                            (timer_value == nims_pkg::TMR_WRAP_TO);
    ev[nims_pkg::B_DESC]  = rx_descriptors_out;
    ev[nims_pkg::B_RES]   = rx_resources_out;
    ev[nims_pkg::B_AREA]  = rx_area_overflow;
    ev[nims_pkg::B_CRC]   = (crc_prev_ff == nims_pkg::TALLY_WRAP_FROM) &
                            (checksum_tally == nims_pkg::TALLY_WRAP_TO);
    ev[nims_pkg::B_FAE]   = (fae_prev_ff == nims_pkg::TALLY_WRAP_FROM) &
                            (alignment_tally == nims_pkg::TALLY_WRAP_TO);
    ev[nims_pkg::B_MP]    = (mp_prev_ff == nims_pkg::TALLY_WRAP_FROM) &
                            (missed_tally == nims_pkg::TALLY_WRAP_TO);
    ev[nims_pkg::B_RFO]   = rx_fifo_overflow;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  assign w1c = (wr_acc && paddr == nims_pkg::ADDR_FLAGS) ?
               (pwdata[15:0] & nims_pkg::WR_MASK) : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable_mask_ff <= nims_pkg::MASK_RST;
    end else if (wr_acc && paddr == nims_pkg::ADDR_MASK) begin
      interrupt_enable_mask_ff <= pwdata[15:0] & nims_pkg::WR_MASK;
    end
  end

  // set beats clear in the same cycle; soft reset does not touch flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_cause_flags_ff <= nims_pkg::FLAGS_RST;
    end else begin
      interrupt_cause_flags_ff <= (interrupt_cause_flags_ff & ~w1c) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_retry_mode_ff <= 1'b0;
      soft_reset            <= 1'b0;
    end else if (wr_acc && paddr == nims_pkg::ADDR_CTRL) begin
      latched_retry_mode_ff <= pwdata[nims_pkg::CTRL_LATCHED_BIT];
      soft_reset            <= pwdata[nims_pkg::CTRL_SWRST_BIT];
    end else begin
      soft_reset <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // apb slave: one wait-free access phase
  // ------------------------------------------------------------
  always_comb begin
    nxt_prdata = 32'h00000000;
    if (paddr == nims_pkg::ADDR_MASK) begin
      nxt_prdata[15:0] = interrupt_enable_mask_ff;
    end else if (paddr == nims_pkg::ADDR_FLAGS) begin
      nxt_prdata[15:0] = interrupt_cause_flags_ff;
    end else if (paddr == nims_pkg::ADDR_CTRL) begin
      nxt_prdata[nims_pkg::CTRL_LATCHED_BIT] = latched_retry_mode_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (rd_acc) begin
        prdata <= nxt_prdata;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt and dma hold
  // ------------------------------------------------------------
  logic [15:0] nxt_flags;
  assign nxt_flags = (interrupt_cause_flags_ff & ~w1c) | ev;

  // registered from next flag value, so irq never runs ahead of status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq      <= 1'b0;
      dma_hold <= 1'b0;
    end else begin
      irq      <= |(nxt_flags & interrupt_enable_mask_ff);
      dma_hold <= latched_retry_mode_ff & nxt_flags[nims_pkg::B_BR];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_irq_cause;
    @(posedge pclk) disable iff (!presetn)
      irq |-> |(interrupt_cause_flags_ff & $past(interrupt_enable_mask_ff));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without enabled flag");

  property p_irq_drop;
    @(posedge pclk) disable iff (!presetn)
      (((interrupt_cause_flags_ff & interrupt_enable_mask_ff) == 16'h0000) &&
       ev == 16'h0000) |=> !irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq stuck high");

  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
      (w1c[nims_pkg::B_RFO] && !ev[nims_pkg::B_RFO]) |=> !interrupt_cause_flags_ff[nims_pkg::B_RFO];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      (interrupt_cause_flags_ff[nims_pkg::B_PACKET_RECEIVED_FLAG] && !w1c[nims_pkg::B_PACKET_RECEIVED_FLAG])
      |=> interrupt_cause_flags_ff[nims_pkg::B_PACKET_RECEIVED_FLAG];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");

  property p_tmr;
    @(posedge pclk) disable iff (!presetn)
      (interrupt_enable_mask_ff[nims_pkg::B_TMR] && ev[nims_pkg::B_TMR]) |=> irq;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer interrupt missing");

  property p_rfo_block;
    @(posedge pclk) disable iff (!presetn)
      (interrupt_enable_mask_ff == 16'h0001 && ev == 16'h0000 && w1c == 16'h0000)
      ##1 (!interrupt_cause_flags_ff[nims_pkg::B_RFO] && $stable(interrupt_enable_mask_ff)
           && ev == 16'h0000) |=> !irq;
  endproperty
  a_rfo_block: assert property (p_rfo_block) else $error("masked flag raised irq");

  property p_br_latched;
    @(posedge pclk) disable iff (!presetn)
      (latched_retry_mode_ff && bus_retry_input && !bus_master &&
       !interrupt_cause_flags_ff[nims_pkg::B_BR]) |=> !interrupt_cause_flags_ff[nims_pkg::B_BR];
  endproperty
  a_br_latched: assert property (p_br_latched) else $error("retry flag set while not master");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      !latched_retry_mode_ff ##1 !latched_retry_mode_ff |-> !dma_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("dma held in unlatched mode");

  property p_transmission_done_flag;
    @(posedge pclk) disable iff (!presetn)
      (!interrupt_cause_flags_ff[nims_pkg::B_TRANSMISSION_DONE_FLAG] && !tx_status_written)
      |=> !interrupt_cause_flags_ff[nims_pkg::B_TRANSMISSION_DONE_FLAG];
  endproperty
  a_transmission_done_flag: assert property (p_transmission_done_flag) else $error("done before status write");

  property p_hb;
    @(posedge pclk) disable iff (!presetn)
      (tx_frame_end ##1 (!heartbeat_pulse && !tx_frame_end)[*8]) |-> hb_armed_ff;
  endproperty
  a_hb: assert property (p_hb) else $error("heartbeat window closed early");
endmodule // nims_top

// ==== test/nims_host_model.sv ====
`timescale 1ns/1ps
// software side of the register bus; the bench calls xfer hierarchically
module nims_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // ----------------------------------------
  // one transfer, held until pready at an edge
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed latency assumed; the bench watchdog ends a hang
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // nims_host_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, x, g) begin tests_run++; if ((g) !== (x)) begin \
  $display("[FAIL] %s exp %0h got %0h", n, x, g); failures++; end end
module tb_top;
  typedef struct {int k; logic [15:0] mask; logic [15:0] flags; logic irq;} nims_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, dma_hold, bm, e, sr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, tv, q;
  logic [15:0] ct, at, mt;
  logic [19:0] ev;
  int          failures, tests_run;
  nims_row_t   rows[$];
  nims_row_t   r;

  nims_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  nims_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_retry_input(ev[14]), .bus_master(bm), .tx_frame_end(ev[13]),
    .heartbeat_pulse(ev[3]), .cam_load_done(ev[12]), .tx_config_read(ev[11]),
    .descriptor_irq_request_bit(ev[2]), .rx_seq_word_written(ev[10]),
    .tx_status_written(ev[1]), .end_of_list_marker(ev[9]), .halt_transmit_command(ev[7]),
    .byte_count_mismatch(ev[15]), .too_many_collisions(ev[8]), .fifo_underrun_error(ev[16]),
    .too_long_deferral(ev[17]), .timer_value(tv), .rx_descriptors_out(ev[6]),
    .rx_resources_out(ev[5]), .rx_area_overflow(ev[4]), .checksum_tally(ct),
    .alignment_tally(at), .missed_tally(mt), .rx_fifo_overflow(ev[0]), .irq(irq),
    .dma_hold(dma_hold), .soft_reset(sr));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] rq;
    logic        re;
    u_host.xfer(1'b1, a, {16'h0000, d}, rq, re);
  endtask
  task automatic rdchk(input string n, input logic [11:0] a, input logic [15:0] x);
    u_host.xfer(1'b0, a, 32'h0, q, e);
    `CHK(n, {16'h0000, x}, q)
  endtask
  task automatic pulse(input logic [19:0] v);
    @(posedge pclk);
    ev <= v;
    @(posedge pclk);
    ev <= 20'h00000;
  endtask
  // wrap sources need two successive counter values
  task automatic fire(input int k);
    @(posedge pclk);
    case (k)
      1: mt <= 16'hffff;
      2: at <= 16'hffff;
      3: ct <= 16'hffff;
      7: tv <= 32'h0000_0000;
      8, 9: ev <= 20'h00002 | (20'h00001 << k);
      11: ev <= 20'h00804;
      default: ev <= 20'h00001 << k;
    endcase
    @(posedge pclk);
    ev <= 20'h00000;
    {mt, at, ct} <= 48'h0;
    tv <= 32'hffff_ffff;
    repeat (k == 13 ? 300 : 3) @(posedge pclk);
  endtask
  task automatic wrap_up();
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    wrap_up();
  end

  initial begin
    presetn = 1'b0;
    bm = 1'b0;
    ev = 20'h00000;
    {mt, at, ct} = 48'h0;
    tv = 32'hffff_ffff;
    for (int k = 0; k < 15; k++) begin
      for (int en = 0; en < 2; en++) begin
        r.k = k;
        r.flags = (k == 8) ? 16'h0300 : (16'h0001 << k);
        r.mask = en ? (16'h0001 << k) : (16'h7fff ^ (16'h0001 << k));
        r.irq = |(r.flags & r.mask);
        rows.push_back(r);
      end
    end
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("mask_rst", nims_pkg::ADDR_MASK, 16'h0000);
    rdchk("flags_rst", nims_pkg::ADDR_FLAGS, 16'h0000);
    // ----------------------------------------
    // table: every source, masked in and out
    // ----------------------------------------
    foreach (rows[i]) begin
      wr(nims_pkg::ADDR_MASK, rows[i].mask);
      fire(rows[i].k);
      rdchk("flags", nims_pkg::ADDR_FLAGS, rows[i].flags);
      `CHK("irq", rows[i].irq, irq)
      wr(nims_pkg::ADDR_FLAGS, rows[i].flags);
      rdchk("cleared", nims_pkg::ADDR_FLAGS, 16'h0000);
      `CHK("irq_low", 1'b0, irq)
    end
    // ----------------------------------------
    // awkward cases
    // ----------------------------------------
    u_host.xfer(1'b0, 12'h020, 32'h0, q, e);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0, q)
    wr(nims_pkg::ADDR_MASK, 16'hffff);
    rdchk("mask_b15", nims_pkg::ADDR_MASK, 16'h7fff);
    for (int j = 15; j < 18; j++) begin
      pulse(20'h00002 | (20'h00001 << j));
      rdchk("abort", nims_pkg::ADDR_FLAGS, 16'h0300);
      wr(nims_pkg::ADDR_FLAGS, 16'h0300);
    end
    pulse(20'h00200);
    repeat (3) @(posedge pclk);
    rdchk("no_status", nims_pkg::ADDR_FLAGS, 16'h0000);
    pulse(20'h00002);
    rdchk("status", nims_pkg::ADDR_FLAGS, 16'h0200);
    wr(nims_pkg::ADDR_FLAGS, 16'h0200);
    pulse(20'h02000);
    repeat (10) @(posedge pclk);
    pulse(20'h00008);
    repeat (300) @(posedge pclk);
    rdchk("heartbeat_ok", nims_pkg::ADDR_FLAGS, 16'h0000);
    wr(nims_pkg::ADDR_MASK, 16'h0001);
    fire(0);
    fire(1);
    `CHK("irq_two", 1'b1, irq)
    wr(nims_pkg::ADDR_FLAGS, 16'h0001);
    rdchk("w1c_zero", nims_pkg::ADDR_FLAGS, 16'h0002);
    `CHK("irq_masked_left", 1'b0, irq)
    wr(nims_pkg::ADDR_CTRL, 16'h0002);
    // pulse launched at the write edge; look one edge later
    @(posedge pclk);
    `CHK("soft_pulse", 1'b1, sr)
    rdchk("soft_rst", nims_pkg::ADDR_FLAGS, 16'h0002);
    wr(nims_pkg::ADDR_CTRL, 16'h0001);
    fire(14);
    rdchk("retry_slave", nims_pkg::ADDR_FLAGS, 16'h0002);
    bm <= 1'b1;
    fire(14);
    `CHK("dma_held", 1'b1, dma_hold)
    wr(nims_pkg::ADDR_FLAGS, 16'h4000);
    @(posedge pclk);
    `CHK("dma_free", 1'b0, dma_hold)
    wr(nims_pkg::ADDR_CTRL, 16'h0000);
    bm <= 1'b0;
    fire(14);
    `CHK("unlatched", 1'b0, dma_hold)
    rdchk("unl_flag", nims_pkg::ADDR_FLAGS, 16'h4002);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("hw_flags", nims_pkg::ADDR_FLAGS, 16'h0000);
    rdchk("hw_mask", nims_pkg::ADDR_MASK, 16'h0000);
    `CHK("hw_irq", 1'b0, irq)
    wrap_up();
  end
endmodule // tb_top
